// ---- verilog/sdp_drive_port.sv ----
// module: two-axis step and direction drive port with apb registers
//
// Contract
// - steps at most 500 kHz, 2 us wide
// - per-axis fault polarity bit, low or high
// - enable active while operating normally
// - fault or emergency stop drops enables
// - step and direction pairs always complementary
// - faults come in, step dir enable out
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module sdp_drive_port
    import sdp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // apb slave
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // drive side inputs
    input  wire logic        x_drive_fault_in_i,
    input  wire logic        z_drive_fault_in_i,
    input  wire logic        y_drive_fault_in_i,
    input  wire logic        estop_i,
    // drive side outputs
    output logic             x_step_pos_o,
    output logic             x_step_neg_o,
    output logic             x_dir_pos_o,
    output logic             x_dir_neg_o,
    output logic             z_step_pos_o,
    output logic             z_step_neg_o,
    output logic             z_dir_pos_o,
    output logic             z_dir_neg_o,
    output logic             x_axis_en_o,
    output logic             z_axis_en_o
);

    sdp_top_state_t s_r;
    sdp_top_state_t s_nxt;

    sdp_axis_if     x_if ();
    sdp_axis_if     z_if ();

    logic [2:0]     fault_raw;
    logic [2:0]     fault_act;
    logic           halt;
    logic           setup_ph;
    logic           access_ph;
    logic           wr_acc;
    logic           mapped;
    logic [31:0]    rd_val;

    // ============================================================
    // fault qualification
    assign fault_raw = {x_drive_fault_in_i, z_drive_fault_in_i, y_drive_fault_in_i};
    // polarity bit 1 means the fault input is active high
    assign fault_act = ~(fault_raw ^ {s_r.pol[POL_X_BIT - POL_Y_BIT],
                                      s_r.pol[POL_Z_BIT - POL_Y_BIT],
                                      s_r.pol[0]});
    assign halt      = ~s_r.en;

    // ============================================================
    // apb decode
    assign setup_ph  = psel_i && !penable_i;
    assign access_ph = psel_i && penable_i;
    assign wr_acc    = access_ph && pwrite_i;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr_i)
            ADDR_CFG:      rd_val[POL_X_BIT:POL_Y_BIT] = s_r.pol;
            ADDR_STATUS:   rd_val = {22'h00_0000, x_if.busy, z_if.busy, x_axis_en_o, z_axis_en_o,
                                     estop_i, fault_act, 2'h0};
            ADDR_X_CMD:    rd_val = {15'h0000, x_if.dir_cur, x_if.remain};
            ADDR_Z_CMD:    rd_val = {15'h0000, z_if.dir_cur, z_if.remain};
            ADDR_X_PERIOD: rd_val[15:0] = s_r.x_period;
            ADDR_Z_PERIOD: rd_val[15:0] = s_r.z_period;
            default:       mapped = 1'b0;
        endcase
    end

    // ============================================================
    // register file and enable
    always_comb begin
        s_nxt = s_r;
        if (setup_ph) begin
            s_nxt.prdata = rd_val;
        end
        if (wr_acc) begin
            if (paddr_i == ADDR_CFG) begin
                s_nxt.pol = pwdata_i[POL_X_BIT:POL_Y_BIT];
            end
            if (paddr_i == ADDR_X_PERIOD) begin
                s_nxt.x_period = pwdata_i[15:0];
            end
            if (paddr_i == ADDR_Z_PERIOD) begin
                s_nxt.z_period = pwdata_i[15:0];
            end
        end
        // enable held active unless any fault or emergency stop
        s_nxt.en = !(|fault_act) && !estop_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_r <= '{prdata: 32'h0000_0000, pol: POL_RST, x_period: PERIOD_RST, z_period: PERIOD_RST,
                     en: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata_o  = s_r.prdata;
    assign pready_o  = 1'b1;
    assign pslverr_o = access_ph && !mapped;

    // ============================================================
    // axis commands
    assign x_if.start  = wr_acc && (paddr_i == ADDR_X_CMD);
    assign x_if.dir    = pwdata_i[CMD_DIR_BIT];
    assign x_if.count  = pwdata_i[15:0];
    assign x_if.period = s_r.x_period;
    assign x_if.halt   = halt;

    assign z_if.start  = wr_acc && (paddr_i == ADDR_Z_CMD);
    assign z_if.dir    = pwdata_i[CMD_DIR_BIT];
    assign z_if.count  = pwdata_i[15:0];
    assign z_if.period = s_r.z_period;
    assign z_if.halt   = halt;

    sdp_axis_gen u_x_axis (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .cmd        (x_if.axis),
        .step_pos_o (x_step_pos_o),
        .step_neg_o (x_step_neg_o),
        .dir_pos_o  (x_dir_pos_o),
        .dir_neg_o  (x_dir_neg_o)
    );

    sdp_axis_gen u_z_axis (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .cmd        (z_if.axis),
        .step_pos_o (z_step_pos_o),
        .step_neg_o (z_step_neg_o),
        .dir_pos_o  (z_dir_pos_o),
        .dir_neg_o  (z_dir_neg_o)
    );

    // ============================================================
    // enable outputs, high means line sinks to ground
    assign x_axis_en_o = s_r.en;
    assign z_axis_en_o = s_r.en;

endmodule // sdp_drive_port

// ---- verilog/sdp_pkg.sv ----
// package: constants, register map and state types of the step and direction drive port
package sdp_pkg;

    // ============================================================
    // timing
    localparam int unsigned   CLK_MHZ        = 250;
    localparam int unsigned   PULSE_NS       = 2000;
    localparam int unsigned   MAX_RATE_KHZ   = 500;
    localparam int unsigned   DIR_GAP_NS     = 200;
    localparam int unsigned   PULSE_CYC_I    = (PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned   MIN_PER_CYC_I  = (CLK_MHZ * 1000 + MAX_RATE_KHZ - 1) / MAX_RATE_KHZ;
    localparam int unsigned   GAP_CYC_I      = (DIR_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned   FLOOR_CYC_I    = (MIN_PER_CYC_I > PULSE_CYC_I + GAP_CYC_I) ?
                                               MIN_PER_CYC_I : PULSE_CYC_I + GAP_CYC_I;
    localparam logic [15:0]   PULSE_CYC      = PULSE_CYC_I[15:0];
    localparam logic [15:0]   GAP_CYC        = GAP_CYC_I[15:0];
    localparam logic [15:0]   PERIOD_FLOOR   = FLOOR_CYC_I[15:0];

    // ============================================================
    // register map (byte addresses)
    localparam logic [7:0]    ADDR_CFG       = 8'h00;
    localparam logic [7:0]    ADDR_STATUS    = 8'h04;
    localparam logic [7:0]    ADDR_X_CMD     = 8'h08;
    localparam logic [7:0]    ADDR_Z_CMD     = 8'h0c;
    localparam logic [7:0]    ADDR_X_PERIOD  = 8'h10;
    localparam logic [7:0]    ADDR_Z_PERIOD  = 8'h14;

    // ============================================================
    // fields
    localparam int unsigned   POL_X_BIT      = 4;
    localparam int unsigned   POL_Z_BIT      = 3;
    localparam int unsigned   POL_Y_BIT      = 2;
    localparam int unsigned   CMD_DIR_BIT    = 16;
    localparam logic [2:0]    POL_RST        = 3'h0;
    localparam logic [15:0]   PERIOD_RST     = 16'h0000;

    // ============================================================
    // types
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_SETUP = 4'b0010,
        S_HIGH  = 4'b0100,
        S_LOW   = 4'b1000
    } sdp_axis_st_t;

    typedef struct packed {
        sdp_axis_st_t st;
        logic         dir;
        logic [15:0]  remain;
        logic [15:0]  period;
        logic [15:0]  cnt;
    } sdp_axis_state_t;

    typedef struct packed {
        logic [31:0]  prdata;
        logic [2:0]   pol;
        logic [15:0]  x_period;
        logic [15:0]  z_period;
        logic         en;
    } sdp_top_state_t;

endpackage

// ---- verilog/sdp_axis_if.sv ----
// interface: command and status between the port top and one axis generator
`timescale 1ns/1ps
interface sdp_axis_if;
    logic        start;
    logic        dir;
    logic [15:0] count;
    logic [15:0] period;
    logic        halt;
    logic        busy;
    logic        dir_cur;
    logic [15:0] remain;

    modport ctl  (output start, dir, count, period, halt, input busy, dir_cur, remain);
    modport axis (input start, dir, count, period, halt, output busy, dir_cur, remain);
endinterface

// ---- verilog/sdp_axis_gen.sv ----
// module: step pulse and direction generator for one axis
`timescale 1ns/1ps
module sdp_axis_gen
    import sdp_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    sdp_axis_if.axis    cmd,
    output logic        step_pos_o,
    output logic        step_neg_o,
    output logic        dir_pos_o,
    output logic        dir_neg_o
);

    sdp_axis_state_t s_r;
    sdp_axis_state_t s_nxt;

    // ============================================================
    // sequencer
    always_comb begin
        s_nxt = s_r;
        unique case (s_r.st)
            S_IDLE: begin
                if (cmd.start && (cmd.count != 16'h0000) && !cmd.halt) begin
                    s_nxt.dir    = cmd.dir;
                    s_nxt.remain = cmd.count;
                    s_nxt.period = (cmd.period < PERIOD_FLOOR) ? PERIOD_FLOOR : cmd.period;
                    s_nxt.cnt    = GAP_CYC - 16'h0001;
                    s_nxt.st     = S_SETUP;
                end
            end
            S_SETUP: begin
                if (cmd.halt) begin
                    s_nxt.remain = 16'h0000;
                    s_nxt.st     = S_IDLE;
                end else if (s_r.cnt == 16'h0000) begin
                    s_nxt.cnt = PULSE_CYC - 16'h0001;
                    s_nxt.st  = S_HIGH;
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            S_HIGH: begin
                if (s_r.cnt == 16'h0000) begin
                    s_nxt.remain = s_r.remain - 16'h0001;
                    s_nxt.cnt    = s_r.period - PULSE_CYC - 16'h0001;
                    s_nxt.st     = S_LOW;
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            S_LOW: begin
                if (s_r.cnt == 16'h0000) begin
                    if ((s_r.remain == 16'h0000) || cmd.halt) begin
                        s_nxt.remain = 16'h0000;
                        s_nxt.st     = S_IDLE;
                    end else begin
                        s_nxt.cnt = PULSE_CYC - 16'h0001;
                        s_nxt.st  = S_HIGH;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            default: begin
                s_nxt = '{st: S_IDLE, dir: 1'b0, remain: 16'h0000, period: PERIOD_FLOOR, cnt: 16'h0000};
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_r <= '{st: S_IDLE, dir: 1'b0, remain: 16'h0000, period: PERIOD_FLOOR, cnt: 16'h0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ============================================================
    // outputs
    assign step_pos_o  = (s_r.st == S_HIGH);
    assign step_neg_o  = (s_r.st != S_HIGH);
    assign dir_pos_o   = s_r.dir;
    assign dir_neg_o   = ~s_r.dir;
    assign cmd.busy    = (s_r.st != S_IDLE);
    assign cmd.dir_cur = s_r.dir;
    assign cmd.remain  = s_r.remain;

endmodule // sdp_axis_gen

// ---- tb/sdp_drive_port_properties.sv ----
// checker: step, direction and enable timing of the drive port
`timescale 1ns/1ps
module sdp_chk (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic estop_i,
    input wire logic x_step_pos_o,
    input wire logic x_step_neg_o,
    input wire logic x_dir_pos_o,
    input wire logic x_dir_neg_o,
    input wire logic z_step_pos_o,
    input wire logic z_step_neg_o,
    input wire logic z_dir_pos_o,
    input wire logic z_dir_neg_o,
    input wire logic x_axis_en_o,
    input wire logic z_axis_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [9:0] x_hi_r;
    logic [9:0] x_lo_r;
    logic [9:0] z_hi_r;
    logic [9:0] z_lo_r;
    // high and low run lengths of the step pulses, low runs saturate
    always_ff @(posedge clk_i) begin
        x_hi_r <= (rst_b_i && x_step_pos_o) ? x_hi_r + 10'h1 : 10'h0;
        z_hi_r <= (rst_b_i && z_step_pos_o) ? z_hi_r + 10'h1 : 10'h0;
        x_lo_r <= (!rst_b_i || x_step_pos_o) ? 10'h0 : x_lo_r + {9'h0, x_lo_r != 10'h3ff};
        z_lo_r <= (!rst_b_i || z_step_pos_o) ? 10'h0 : z_lo_r + {9'h0, z_lo_r != 10'h3ff};
    end
    property p_x_step_pair; x_step_neg_o == !x_step_pos_o; endproperty
    a_x_step_pair: assert property (p_x_step_pair) else $error("x step pair");
    property p_z_step_pair; z_step_neg_o == !z_step_pos_o; endproperty
    a_z_step_pair: assert property (p_z_step_pair) else $error("z step pair");
    property p_x_dir_pair; x_dir_neg_o == !x_dir_pos_o; endproperty
    a_x_dir_pair: assert property (p_x_dir_pair) else $error("x dir pair");
    property p_z_dir_pair; z_dir_neg_o == !z_dir_pos_o; endproperty
    a_z_dir_pair: assert property (p_z_dir_pair) else $error("z dir pair");
    property p_x_width; $fell(x_step_pos_o) |-> x_hi_r == 10'd500; endproperty
    a_x_width: assert property (p_x_width) else $error("x pulse width");
    property p_z_width; $fell(z_step_pos_o) |-> z_hi_r == 10'd500; endproperty
    a_z_width: assert property (p_z_width) else $error("z pulse width");
    property p_x_gap; $rose(x_step_pos_o) |-> x_lo_r >= 10'd50; endproperty
    a_x_gap: assert property (p_x_gap) else $error("x step rate");
    property p_z_gap; $rose(z_step_pos_o) |-> z_lo_r >= 10'd50; endproperty
    a_z_gap: assert property (p_z_gap) else $error("z step rate");
    property p_x_dir_hold; (x_step_pos_o || $fell(x_step_pos_o)) |-> $stable(x_dir_pos_o); endproperty
    a_x_dir_hold: assert property (p_x_dir_hold) else $error("x dir moved");
    property p_z_dir_hold; (z_step_pos_o || $fell(z_step_pos_o)) |-> $stable(z_dir_pos_o); endproperty
    a_z_dir_hold: assert property (p_z_dir_hold) else $error("z dir moved");
    property p_estop; estop_i |=> !x_axis_en_o && !z_axis_en_o; endproperty
    a_estop: assert property (p_estop) else $error("enable kept");
    property p_en_same; x_axis_en_o == z_axis_en_o; endproperty
    a_en_same: assert property (p_en_same) else $error("enables differ");
    property p_halt; !x_axis_en_o && !x_step_pos_o |=> !x_step_pos_o; endproperty
    a_halt: assert property (p_halt) else $error("x step while off");
    property p_z_halt; !z_axis_en_o && !z_step_pos_o |=> !z_step_pos_o; endproperty
    a_z_halt: assert property (p_z_halt) else $error("z step while off");
endmodule // sdp_chk

bind sdp_drive_port sdp_chk i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .estop_i(estop_i),
    .x_step_pos_o(x_step_pos_o), .x_step_neg_o(x_step_neg_o), .x_dir_pos_o(x_dir_pos_o),
    .x_dir_neg_o(x_dir_neg_o), .z_step_pos_o(z_step_pos_o), .z_step_neg_o(z_step_neg_o),
    .z_dir_pos_o(z_dir_pos_o), .z_dir_neg_o(z_dir_neg_o), .x_axis_en_o(x_axis_en_o),
    .z_axis_en_o(z_axis_en_o));

// ---- tb/sdp_drive_model.sv ----
// model: one external drive unit that counts steps and raises its alarm on request
`timescale 1ns/1ps
module sdp_drive_model (
    input  wire logic   step_pos_i,
    input  wire logic   dir_pos_i,
    input  wire logic   en_i,
    input  wire logic   flt_i,
    output logic        alarm_o,
    output logic [15:0] cnt_o
);
    // alarm line is active low and always driven
    assign alarm_o = !flt_i;
    // steps only count while the unit is enabled
    initial begin
        cnt_o = 16'h0;
        forever begin
            @(posedge step_pos_i);
            if (en_i) begin
                cnt_o <= dir_pos_i ? cnt_o + 16'h1 : cnt_o - 16'h1;
            end
        end
    end
endmodule // sdp_drive_model

// ---- tb/two_axis_step_dir_drive_port_test.sv ----
// testbench: register, enable and step tests of the drive port
`timescale 1ns/1ps
module two_axis_step_dir_drive_port_test
    import sdp_pkg::*;
;
    logic        clk_i, rst_b_i, psel, penable, pwrite, estop, y_line, x_flt, z_flt;
    logic        pready, perr, err, x_en, z_en, x_sp, x_dp, z_sp, z_dp, x_al, z_al;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] x_cnt, z_cnt;
    int          n_errors = 0;
    int          n_compared = 0;

    sdp_drive_port i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(perr), .x_drive_fault_in_i(x_al), .z_drive_fault_in_i(z_al), .y_drive_fault_in_i(y_line),
        .estop_i(estop), .x_step_pos_o(x_sp), .x_step_neg_o(), .x_dir_pos_o(x_dp), .x_dir_neg_o(),
        .z_step_pos_o(z_sp), .z_step_neg_o(), .z_dir_pos_o(z_dp), .z_dir_neg_o(), .x_axis_en_o(x_en),
        .z_axis_en_o(z_en));
    sdp_drive_model i_xm (.step_pos_i(x_sp), .dir_pos_i(x_dp), .en_i(x_en), .flt_i(x_flt),
        .alarm_o(x_al), .cnt_o(x_cnt));
    sdp_drive_model i_zm (.step_pos_i(z_sp), .dir_pos_i(z_dp), .en_i(z_en), .flt_i(z_flt),
        .alarm_o(z_al), .cnt_o(z_cnt));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is seen
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = perr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic wait_idle;
        do begin
            repeat (100) @(posedge clk_i);
            xfer(ADDR_STATUS, 1'b0, 32'h0);
        end while (rdat[9:8] !== 2'b00);
    endtask

    task automatic end_of_test;
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_i);
        n_errors++;
        end_of_test;
    end

    initial begin
        rst_b_i = 1'b0;
        {psel, penable, pwrite, estop, x_flt, z_flt} = 6'h0;
        y_line = 1'b1;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(ADDR_CFG, 32'h0);
        rd(ADDR_STATUS, 32'h0c0);
        xfer(ADDR_STATUS, 1'b1, 32'h3ff);
        rd(ADDR_STATUS, 32'h0c0);
        rd(8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 2; i < 5; i++) begin
            xfer(ADDR_CFG, 1'b1, 32'h1 << i);
            rd(ADDR_CFG, 32'h1 << i);
            rd(ADDR_STATUS, 32'h1 << i);
        end
        xfer(ADDR_CFG, 1'b1, 32'h0);
        estop <= 1'b1;
        rd(ADDR_STATUS, 32'h020);
        estop <= 1'b0;
        xfer(ADDR_X_PERIOD, 1'b1, 32'h258);
        rd(ADDR_X_PERIOD, 32'h258);
        xfer(ADDR_Z_PERIOD, 1'b1, 32'h1f4);
        rd(ADDR_Z_PERIOD, 32'h1f4);
        xfer(ADDR_X_CMD, 1'b1, 32'h10003);
        xfer(ADDR_Z_CMD, 1'b1, 32'h2);
        xfer(ADDR_X_CMD, 1'b1, 32'h7);
        rd(ADDR_STATUS, 32'h3c0);
        rd(ADDR_X_CMD, 32'h10003);
        wait_idle;
        chk({16'h0, x_cnt}, 32'h3);
        chk({16'h0, z_cnt}, 32'hfffe);
        rd(ADDR_X_CMD, 32'h10000);
        xfer(ADDR_Z_CMD, 1'b1, 32'h10000);
        rd(ADDR_Z_CMD, 32'h0);
        xfer(ADDR_X_CMD, 1'b1, 32'h10005);
        repeat (700) @(posedge clk_i);
        x_flt <= 1'b1;
        rd(ADDR_STATUS, 32'h210);
        wait_idle;
        chk({16'h0, x_cnt}, 32'h5);
        rd(ADDR_X_CMD, 32'h10000);
        xfer(ADDR_X_CMD, 1'b1, 32'h10001);
        x_flt <= 1'b0;
        rd(ADDR_STATUS, 32'h0c0);
        end_of_test;
    end
endmodule // two_axis_step_dir_drive_port_test
